// *** hw/pmi_irq_ctrl.sv ***
// interrupt flags, masks and interrupt pin drive
`timescale 1ns/1ns
// How it works
// [R1] switch 3 fault flag at bit 5 while switch 3 is thermally disabled
// [R2] switch 2 fault flag at bit 4 on overtemperature or input undervoltage
// [R3] switch 1 fault flag at bit 3 while switch 1 is thermally disabled
// [R4] current-limit flags bits 2..0 read 1 only while limiting
// [R5] switch flag register resets to zero, top two bits read zero
// [R6] mask 0 lets an event pull the pin low, mask 1 blocks it
// [R7] masks only gate the pin; flags keep working
// [R8] system mask bits 5,4,3: programming voltage, mains detect, button
// [R9] system mask bits 2,1,0: overtemperature, coin acquisition, programming done
// [R10] switch mask bits 5,4,3: switch 3,2,1 fault masks
// [R11] switch mask bits 2,1,0: switch 3,2,1 current-limit masks
// [R12] both masks reset to zero, top two bits read zero
// [R13] mains detect flag raised on any level change of its input
// [R14] button flag raised on any level change of its input
// [R15] pin held low while any unmasked flag is set
module pmi_irq_ctrl
   import pmi_pkg::*;
(
   input  wire logic         clk,                 // core clock, 100 MHz
   input  wire logic         rst_n,               // async reset, active low
   input  pmi_reg_req_t      reg_req,             // register access from serial engine
   output logic        [7:0] reg_rdata,           // read data, valid cycle after rd
   input  pmi_sw_cond_t      sw_cond,             // load switch monitor levels
   input  pmi_sys_evt_t      sys_evt,             // system event pulses
   input  wire logic         mains_detect_input,  // mains detect level
   input  wire logic         push_button_input,   // push-button level
   output logic              mains_level,         // last sampled mains level
   output logic              button_level,        // last sampled button level
   output logic              irq_out_low          // interrupt pin, active low
);

   pmi_main_state_t st;
   pmi_main_state_t next_st;
   logic [5:0]      sys_set;
   logic [5:0]      sys_flags;
   logic            sys_clr;
   logic            mains_change;
   logic            button_change;

   // first cycle after reset only samples, so reset gives no false edge
   assign mains_change  = st.primed & (mains_detect_input ^ st.mains_prev);   // see [R13]
   assign button_change = st.primed & (push_button_input ^ st.button_prev);   // see [R14]

   always_comb
   begin
      sys_set                       = '0;
      sys_set[PMI_BIT_PROG_VOLTAGE] = sys_evt.prog_voltage;
      sys_set[PMI_BIT_MAINS]        = mains_change;
      sys_set[PMI_BIT_BUTTON]       = button_change;
      sys_set[PMI_BIT_OVERTEMP]     = sys_evt.overtemp;
      sys_set[PMI_BIT_COIN_ACQ]     = sys_evt.coin_acq_done;
      sys_set[PMI_BIT_PROG_DONE]    = sys_evt.prog_done;
   end

   // reading the system flags consumes them
   assign sys_clr = reg_req.rd & (reg_req.addr == PMI_SYS_FLAGS_ADDR);

   pmi_sticky_flags #(
      .W     (PMI_FIELD_W)
   ) u_sys_flags (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (sys_set),
      .clr   (sys_clr),
      .flags (sys_flags)
   );

   always_comb
   begin
      next_st             = st;
      next_st.primed      = 1'b1;
      next_st.mains_prev  = mains_detect_input;
      next_st.button_prev = push_button_input;

      // level flags track the monitors regardless of masks
      next_st.sw_flags[PMI_BIT_SW3_FAULT]  = sw_cond.fault[2];    // see [R1]
      next_st.sw_flags[PMI_BIT_SW2_FAULT]  = sw_cond.fault[1];    // see [R2]
      next_st.sw_flags[PMI_BIT_SW1_FAULT]  = sw_cond.fault[0];    // see [R3]
      next_st.sw_flags[PMI_BIT_SW3_ILIMIT] = sw_cond.ilimit[2];   // see [R4]
      next_st.sw_flags[PMI_BIT_SW2_ILIMIT] = sw_cond.ilimit[1];   // see [R4]
      next_st.sw_flags[PMI_BIT_SW1_ILIMIT] = sw_cond.ilimit[0];   // see [R4]

      if (reg_req.wr)
      begin
         case (reg_req.addr)
            PMI_SYS_MASK_ADDR: next_st.sys_mask = reg_req.wdata[5:0];   // see [R8] see [R9]
            PMI_SW_MASK_ADDR:  next_st.sw_mask  = reg_req.wdata[5:0];   // see [R10] see [R11]
            default:           next_st.sw_mask  = st.sw_mask;
         endcase
      end

      if (reg_req.rd)
      begin
         case (reg_req.addr)
            PMI_SYS_FLAGS_ADDR: next_st.rdata = {2'h0, sys_flags};
            PMI_SW_FLAGS_ADDR:  next_st.rdata = {2'h0, st.sw_flags};   // see [R5]
            PMI_SYS_MASK_ADDR:  next_st.rdata = {2'h0, st.sys_mask};   // see [R12]
            PMI_SW_MASK_ADDR:   next_st.rdata = {2'h0, st.sw_mask};    // see [R12]
            default:            next_st.rdata = PMI_RDATA_RESET;
         endcase
      end

      // masks gate only the pin, never the flags
      next_st.irq_low = ~(|(sys_flags & ~st.sys_mask) | |(st.sw_flags & ~st.sw_mask));   // see [R6] see [R7] see [R15]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st             <= '0;
         st.sys_mask    <= PMI_FIELD_RESET;   // see [R12]
         st.sw_mask     <= PMI_FIELD_RESET;   // see [R12]
         st.sw_flags    <= PMI_FIELD_RESET;   // see [R5]
         st.rdata       <= PMI_RDATA_RESET;
         st.irq_low     <= PMI_IRQ_IDLE;
      end
      else
         st <= next_st;
   end

   assign reg_rdata    = st.rdata;
   assign irq_out_low  = st.irq_low;
   assign mains_level  = st.mains_prev;
   assign button_level = st.button_prev;

   sequence s_mains_toggle;
      st.primed && (mains_detect_input != st.mains_prev);
   endsequence

   sequence s_button_toggle;
      st.primed && (push_button_input != st.button_prev);
   endsequence

   sequence s_sys_read;
      reg_req.rd && (reg_req.addr == PMI_SYS_FLAGS_ADDR);
   endsequence

   chk_sw3_fault_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R1]
      sw_cond.fault[2] |=> st.sw_flags[PMI_BIT_SW3_FAULT])
      else $error("switch 3 fault flag not set");

   chk_sw2_fault_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R2]
      sw_cond.fault[1] |=> st.sw_flags[PMI_BIT_SW2_FAULT])
      else $error("switch 2 fault flag not set");

   chk_sw1_fault_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R3]
      1'b1 |=> st.sw_flags[PMI_BIT_SW1_FAULT] == $past(sw_cond.fault[0]))
      else $error("switch 1 fault flag wrong");

   chk_ilimit_follow: assert property (@(posedge clk) disable iff (!rst_n)   // see [R4]
      1'b1 |=> st.sw_flags[2:0] == $past(sw_cond.ilimit))
      else $error("current-limit flags do not follow monitor");

   chk_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_n)   // see [R5]
      reg_req.rd |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits read nonzero");

   chk_sw_flags_read: assert property (@(posedge clk) disable iff (!rst_n)   // see [R5]
      reg_req.rd && reg_req.addr == PMI_SW_FLAGS_ADDR |=> reg_rdata[5:0] == $past(st.sw_flags))
      else $error("switch flag read mismatch");

   chk_unmasked_pulls_low: assert property (@(posedge clk) disable iff (!rst_n)   // see [R6]
      (|(st.sw_flags & ~st.sw_mask)) |=> !irq_out_low)
      else $error("unmasked switch flag did not assert pin");

   chk_pin_release_quiet: assert property (@(posedge clk) disable iff (!rst_n)   // see [R15]
      !(|(sys_flags & ~st.sys_mask)) && !(|(st.sw_flags & ~st.sw_mask)) |=> irq_out_low)
      else $error("pin low with no unmasked flag");

   chk_mask_keeps_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R7]
      st.sw_mask[PMI_BIT_SW1_FAULT] && sw_cond.fault[0] |=> st.sw_flags[PMI_BIT_SW1_FAULT] ##1 irq_out_low
         || !st.sw_mask[PMI_BIT_SW1_FAULT] || (|(sys_flags & ~st.sys_mask)) || (|(st.sw_flags & ~st.sw_mask)))
      else $error("masked flag lost or pin asserted");

   chk_sys_mask_write: assert property (@(posedge clk) disable iff (!rst_n)   // see [R8] see [R9]
      reg_req.wr && reg_req.addr == PMI_SYS_MASK_ADDR |=> st.sys_mask == $past(reg_req.wdata[5:0]))
      else $error("system mask write lost");

   chk_sw_mask_write: assert property (@(posedge clk) disable iff (!rst_n)   // see [R10] see [R11]
      reg_req.wr && reg_req.addr == PMI_SW_MASK_ADDR ##1 reg_req.rd && reg_req.addr == PMI_SW_MASK_ADDR
         |=> reg_rdata == {2'h0, $past(reg_req.wdata[5:0], 2)})
      else $error("switch mask readback wrong");

   chk_mask_reset_zero: assert property (@(posedge clk)   // see [R12]
      !rst_n |=> st.sys_mask == 6'h00 && st.sw_mask == 6'h00 || !rst_n)
      else $error("mask not zero after reset");

   chk_mains_edge_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R13]
      s_mains_toggle |=> sys_flags[PMI_BIT_MAINS])
      else $error("mains change not flagged");

   chk_button_edge_flag: assert property (@(posedge clk) disable iff (!rst_n)   // see [R14]
      s_button_toggle |=> sys_flags[PMI_BIT_BUTTON])
      else $error("button change not flagged");

   chk_sys_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
      s_sys_read and !(|sys_set) |=> sys_flags == 6'h00)
      else $error("system flags not cleared by read");

   chk_sys_unmasked_low: assert property (@(posedge clk) disable iff (!rst_n)   // see [R6]
      (|(sys_flags & ~st.sys_mask)) |=> !irq_out_low)
      else $error("unmasked system flag did not assert pin");

   chk_sw3_fault_clear: assert property (@(posedge clk) disable iff (!rst_n)   // see [R1]
      !sw_cond.fault[2] |=> !st.sw_flags[PMI_BIT_SW3_FAULT])
      else $error("switch 3 fault flag stuck");

   chk_sw2_fault_clear: assert property (@(posedge clk) disable iff (!rst_n)   // see [R2]
      !sw_cond.fault[1] |=> !st.sw_flags[PMI_BIT_SW2_FAULT])
      else $error("switch 2 fault flag stuck");

   chk_flag_reg_readonly: assert property (@(posedge clk) disable iff (!rst_n)   // see [R5]
      reg_req.wr && reg_req.addr == PMI_SW_FLAGS_ADDR |=> $stable(st.sys_mask) && $stable(st.sw_mask))
      else $error("write to switch flag register changed a mask");

   chk_mains_level_copy: assert property (@(posedge clk) disable iff (!rst_n)   // see [R13]
      1'b1 |=> mains_level == $past(mains_detect_input))
      else $error("mains level copy wrong");

   chk_no_reset_edge: assert property (@(posedge clk) disable iff (!rst_n)   // see [R13] [R14]
      !st.primed |=> !sys_flags[PMI_BIT_MAINS] && !sys_flags[PMI_BIT_BUTTON])
      else $error("false input edge flagged after reset");

endmodule

// *** hw/pmi_pkg.sv ***
// constants and carrier types for the interrupt flag and mask block
package pmi_pkg;

   localparam logic [7:0] PMI_SYS_FLAGS_ADDR = 8'h01;
   localparam logic [7:0] PMI_SW_FLAGS_ADDR  = 8'h02;
   localparam logic [7:0] PMI_SYS_MASK_ADDR  = 8'h03;
   localparam logic [7:0] PMI_SW_MASK_ADDR   = 8'h04;

   localparam int         PMI_FIELD_W        = 6;
   localparam logic [5:0] PMI_FIELD_RESET    = 6'h00;
   localparam logic [7:0] PMI_RDATA_RESET    = 8'h00;
   localparam logic       PMI_IRQ_IDLE       = 1'b1;

   // system event and mask positions
   localparam int PMI_BIT_PROG_VOLTAGE = 5;
   localparam int PMI_BIT_MAINS        = 4;
   localparam int PMI_BIT_BUTTON       = 3;
   localparam int PMI_BIT_OVERTEMP     = 2;
   localparam int PMI_BIT_COIN_ACQ     = 1;
   localparam int PMI_BIT_PROG_DONE    = 0;

   // switch event and mask positions
   localparam int PMI_BIT_SW3_FAULT  = 5;
   localparam int PMI_BIT_SW2_FAULT  = 4;
   localparam int PMI_BIT_SW1_FAULT  = 3;
   localparam int PMI_BIT_SW3_ILIMIT = 2;
   localparam int PMI_BIT_SW2_ILIMIT = 1;
   localparam int PMI_BIT_SW1_ILIMIT = 0;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } pmi_reg_req_t;

   // index 2 is switch 3, index 0 is switch 1
   typedef struct packed {
      logic [2:0] fault;
      logic [2:0] ilimit;
   } pmi_sw_cond_t;

   typedef struct packed {
      logic prog_voltage;
      logic overtemp;
      logic coin_acq_done;
      logic prog_done;
   } pmi_sys_evt_t;

   typedef struct packed {
      logic [5:0] sys_mask;
      logic [5:0] sw_mask;
      logic [5:0] sw_flags;
      logic       mains_prev;
      logic       button_prev;
      logic       primed;
      logic [7:0] rdata;
      logic       irq_low;
   } pmi_main_state_t;

endpackage

// *** hw/pmi_sticky_flags.sv ***
// sticky event flags, set by hardware, cleared as a group
`timescale 1ns/1ns
module pmi_sticky_flags
   import pmi_pkg::*;
#(
   parameter int W = PMI_FIELD_W
)
(
   input  wire logic         clk,    // core clock
   input  wire logic         rst_n,  // async reset, active low
   input  wire logic [W-1:0] set,    // per-flag set pulse
   input  wire logic         clr,    // clear all flags
   output logic      [W-1:0] flags   // flag state
);

   typedef struct packed {
      logic [W-1:0] flags;
   } pmi_sticky_state_t;

   pmi_sticky_state_t st;
   pmi_sticky_state_t next_st;

   always_comb
   begin
      next_st = st;
      for (int i = 0; i < W; i++)
      begin
         // set beats a clear in the same cycle so no event is lost
         next_st.flags[i] = set[i] | (st.flags[i] & ~clr);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign flags = st.flags;

   chk_set_beats_clr: assert property (@(posedge clk) disable iff (!rst_n)
      set[0] |=> flags[0])
      else $error("flag set lost against clear");

endmodule

// *** tb/pmi_host_model.sv ***
// host-side model issuing register reads and writes
`timescale 1ns/1ns
module pmi_host_model
   import pmi_pkg::*;
(
   input  wire logic   clk,     // core clock
   output pmi_reg_req_t reg_req  // register request toward the block
);
   initial reg_req = '0;

   // random idle gap of one cycle or more between single requests
   task automatic issue(input logic [7:0] addr, input logic wr, input logic [7:0] data);
      repeat ($urandom_range(2)) @(negedge clk);
      @(negedge clk);
      reg_req = '{addr: addr, wr: wr, rd: ~wr, wdata: data};
      @(negedge clk);
      // released bus shows inverted values, not the last request
      reg_req = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
   endtask

   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      issue(addr, 1'b1, data);
   endtask

   task automatic rd_reg(input logic [7:0] addr);
      issue(addr, 1'b0, 8'h00);
   endtask

   // write then read of one address in consecutive cycles
   task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      reg_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
      @(negedge clk);
      reg_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: ~data};
      @(negedge clk);
      reg_req = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: data};
   endtask
endmodule

// *** tb/tb.sv ***
// self-checking testbench for the interrupt flag and mask block
`timescale 1ns/1ns
module tb
   import pmi_pkg::*;
();
   logic         clk;
   logic         rst_n;
   pmi_reg_req_t reg_req;
   logic   [7:0] reg_rdata;
   pmi_sw_cond_t sw_cond;
   pmi_sys_evt_t sys_evt;
   logic         mains_in;
   logic         button_in;
   logic         mains_level;
   logic         button_level;
   logic         irq_out_low;
   logic         rd_seen;
   logic   [7:0] exp_q[$];
   logic   [7:0] m;
   int           num_errors;
   int           num_checks;

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   pmi_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .sw_cond(sw_cond), .sys_evt(sys_evt), .mains_detect_input(mains_in),
      .push_button_input(button_in), .mains_level(mains_level), .button_level(button_level),
      .irq_out_low(irq_out_low));

   pmi_host_model host (.clk(clk), .reg_req(reg_req));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      host.rd_reg(addr);
   endtask

   // pin is registered from registered flags, so allow two edges plus margin
   task automatic irq_chk(input logic exp);
      repeat (3) @(negedge clk);
      chk({7'h00, irq_out_low}, {7'h00, exp});
   endtask

   task automatic fire(input int i);
      case (i)
         PMI_BIT_MAINS:  mains_in = ~mains_in;
         PMI_BIT_BUTTON: button_in = ~button_in;
         default:
         begin
            sys_evt = '{prog_voltage: i == PMI_BIT_PROG_VOLTAGE, overtemp: i == PMI_BIT_OVERTEMP,
                        coin_acq_done: i == PMI_BIT_COIN_ACQ, prog_done: i == PMI_BIT_PROG_DONE};
            @(negedge clk);
            sys_evt = '0;
         end
      endcase
   endtask

   // read data lands the edge after the strobe; compare at the next falling edge
   always @(posedge clk) rd_seen <= reg_req.rd;
   always @(negedge clk)
      if (rd_seen === 1'b1)
         chk(reg_rdata, exp_q.pop_front());

   initial
   begin
      repeat (8000) @(posedge clk);
      num_errors++;
      end_sim();
   end

   initial
   begin
      void'($urandom(32'h47f96e8f));
      rst_n = 1'b0;
      sw_cond = '0;
      sys_evt = '0;
      mains_in = 1'b0;
      button_in = 1'b0;
      num_errors = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      chk({7'h00, irq_out_low}, 8'h01);
      for (int a = 1; a <= 5; a++) rd_chk(8'(a), 8'h00);
      for (int a = 3; a <= 4; a++)
         repeat (4)
         begin
            m = 8'($urandom);
            host.wr_reg(8'(a), m);
            rd_chk(8'(a), {2'b00, m[5:0]});
            m = 8'($urandom);
            exp_q.push_back({2'b00, m[5:0]});
            host.wr_rd(8'(a), m);
         end
      host.wr_reg(PMI_SW_FLAGS_ADDR, 8'hff);
      rd_chk(PMI_SW_FLAGS_ADDR, 8'h00);
      // masks must come back to zero after a reset in mid-run, and
      // inputs sitting high across it must not look like an edge
      @(negedge clk) rst_n = 1'b0;
      mains_in = 1'b1;
      button_in = 1'b1;
      @(negedge clk) rst_n = 1'b1;
      rd_chk(PMI_SYS_MASK_ADDR, 8'h00);
      rd_chk(PMI_SW_MASK_ADDR, 8'h00);
      rd_chk(PMI_SYS_FLAGS_ADDR, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         sw_cond = pmi_sw_cond_t'(6'h01 << i);
         irq_chk(1'b0);
         rd_chk(PMI_SW_FLAGS_ADDR, 8'h01 << i);
         host.wr_reg(PMI_SW_MASK_ADDR, 8'h01 << i);
         irq_chk(1'b1);
         rd_chk(PMI_SW_FLAGS_ADDR, 8'h01 << i);
         sw_cond = '0;
         host.wr_reg(PMI_SW_MASK_ADDR, 8'h00);
         irq_chk(1'b1);
      end
      // each source unmasked then masked; level inputs toggle both ways
      for (int i = 0; i < 6; i++)
         for (int k = 0; k < 2; k++)
         begin
            host.wr_reg(PMI_SYS_MASK_ADDR, k == 1 ? 8'h01 << i : 8'h00);
            fire(i);
            irq_chk(k == 1);
            rd_chk(PMI_SYS_FLAGS_ADDR, 8'h01 << i);
            irq_chk(1'b1);
            chk({6'h00, mains_level, button_level}, {6'h00, mains_in, button_in});
         end
      repeat (4) @(negedge clk);
      end_sim();
   end
endmodule
